//--- rtdt_params.svh
`ifndef RTDT_PARAMS_SVH
`define RTDT_PARAMS_SVH

// ==========================================================
// Oscillator trim register layout
`define RTDT_TRIM_RESET 8'h00
`define RTDT_TRIM_SIGN_BIT 7
`define RTDT_MAG_ZERO 7'h00

// ==========================================================
// Prescaler and timekeeping
`define RTDT_PRE_W 15
`define RTDT_PRE_LAST 15'h7FFF
`define RTDT_PRE_ONE 15'h0001
`define RTDT_SLOT_LAST 8'hFF
`define RTDT_SLOT_MSB 7
`define RTDT_SEC_LAST 6'h3B
`define RTDT_SEC_ONE 6'h01
`define RTDT_SEC_ZERO 6'h00
`define RTDT_HOLD_ZERO 8'h00
`define RTDT_HOLD_ONE 8'h01

// ==========================================================
// Square-wave taps into the prescaler
`define RTDT_TAP_1HZ 14
`define RTDT_TAP_4K 2
`define RTDT_TAP_8K 1
`define RTDT_TAP_64HZ 8

// ==========================================================
// Square-wave rate codes
`define RTDT_RATE_1HZ 2'h0
`define RTDT_RATE_4K 2'h1
`define RTDT_RATE_8K 2'h2
`define RTDT_RATE_32K 2'h3

`endif

//--- rtdt_pkg.sv
package rtdt_pkg;

	// Control bits held by the serial-bus front end
	typedef struct packed {
		logic osc_start;
		logic ext_clock_input_enable;
		logic square_wave_enable;
		logic coarse_trim_enable;
		logic [1:0] square_wave_rate_select;
	} rtdt_ctrl_t;

	// Oscillator trim register
	typedef struct packed {
		logic add_cycles;
		logic [6:0] trim_magnitude;
	} rtdt_trim_t;

endpackage : rtdt_pkg

//--- rtdt_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rtdt_pin_sync (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out
);

	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// ==========================================================
	// Two-flop synchroniser, first stage read only by the second
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level_out = sync_ff;
	assign rise_out = sync_ff & ~last_ff;

endmodule : rtdt_pin_sync

`default_nettype wire

//--- rtdt_trim.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtdt_params.svh"

module rtdt_trim (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic osc_pin,
	input wire rtdt_pkg::rtdt_ctrl_t ctrl,
	input wire logic trim_wr,
	input wire rtdt_pkg::rtdt_trim_t trim_wdata,
	output rtdt_pkg::rtdt_trim_t trim_rdata,
	output logic second_tick,
	output logic [5:0] seconds_count,
	output logic multi_function_output_pin
);
	import rtdt_pkg::*;

	logic rst_meta_ff;
	logic rst_sync_ff;
	logic osc_level;
	logic osc_rise;
	rtdt_trim_t trim_ff;
	logic [14:0] pre_ff;
	logic [14:0] nxt_pre;
	logic [5:0] sec_ff;
	logic [5:0] nxt_sec;
	logic [7:0] hold_ff;
	logic [7:0] nxt_hold;
	logic tick_ff;
	logic mfp_ff;
	logic nxt_mfp;

	// ==========================================================
	// Reset release
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ==========================================================
	// Oscillator pin, crystal or external clock
	rtdt_pin_sync u_osc_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_sync_ff),
		.pin_in(osc_pin),
		.level_out(osc_level),
		.rise_out(osc_rise)
	);

	// ==========================================================
	// Decode
	wire osc_run = ctrl.osc_start | ctrl.ext_clock_input_enable;
	wire osc_tick = osc_rise & osc_run;
	wire holding = hold_ff != `RTDT_HOLD_ZERO;
	wire [14:0] pre_inc = pre_ff + `RTDT_PRE_ONE;
	wire sec_wrap = pre_ff == `RTDT_PRE_LAST;
	wire minute_slot = sec_wrap && (sec_ff == `RTDT_SEC_LAST);
	wire coarse_slot = pre_ff[`RTDT_SLOT_MSB:0] == `RTDT_SLOT_LAST;
	wire [7:0] trim_cycles = {trim_ff.trim_magnitude, 1'b0};
	wire trim_on = trim_ff.trim_magnitude != `RTDT_MAG_ZERO;
	wire trim_slot = ctrl.coarse_trim_enable ? coarse_slot : minute_slot;
	wire trim_evt = osc_tick && !holding && trim_slot && trim_on;
	// Jump lands inside one 256-cycle slot, so no second is skipped
	wire [14:0] pre_jump = pre_inc + {7'h00, trim_cycles};

	// ==========================================================
	// Prescaler with trim
	always_comb
	begin
		nxt_pre = pre_ff;
		nxt_hold = hold_ff;
		nxt_sec = sec_ff;
		if (osc_tick)
		begin
			if (holding)
			begin
				nxt_hold = hold_ff - `RTDT_HOLD_ONE;
			end
			else
			begin
				nxt_pre = pre_inc;
				if (trim_evt)
				begin
					if (trim_ff.add_cycles)
						nxt_hold = trim_cycles;
					else
						nxt_pre = pre_jump;
				end
				if (sec_wrap)
					nxt_sec = (sec_ff == `RTDT_SEC_LAST) ? `RTDT_SEC_ZERO
						: sec_ff + `RTDT_SEC_ONE;
			end
		end
	end

	// ==========================================================
	// Square wave selection
	always_comb
	begin
		nxt_mfp = 1'b0;
		if (ctrl.square_wave_enable)
		begin
			// coarse mode shows trimmed 64 Hz
			if (ctrl.coarse_trim_enable)
				nxt_mfp = pre_ff[`RTDT_TAP_64HZ];
			else
			begin
				unique case (ctrl.square_wave_rate_select)
					`RTDT_RATE_1HZ: nxt_mfp = pre_ff[`RTDT_TAP_1HZ];
					`RTDT_RATE_4K: nxt_mfp = pre_ff[`RTDT_TAP_4K];
					`RTDT_RATE_8K: nxt_mfp = pre_ff[`RTDT_TAP_8K];
					`RTDT_RATE_32K: nxt_mfp = osc_level;
				endcase
			end
		end
	end

	// ==========================================================
	// State
	always_ff @(posedge sys_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			trim_ff <= `RTDT_TRIM_RESET;
			pre_ff <= '0;
			sec_ff <= `RTDT_SEC_ZERO;
			hold_ff <= `RTDT_HOLD_ZERO;
			tick_ff <= 1'b0;
			mfp_ff <= 1'b0;
		end
		else
		begin
			if (trim_wr)
				trim_ff <= trim_wdata;
			pre_ff <= nxt_pre;
			sec_ff <= nxt_sec;
			hold_ff <= nxt_hold;
			// time registers see only whole seconds
			tick_ff <= osc_tick && !holding && sec_wrap;
			mfp_ff <= nxt_mfp;
		end
	end

	assign trim_rdata = trim_ff;
	assign second_tick = tick_ff;
	assign seconds_count = sec_ff;
	assign multi_function_output_pin = mfp_ff;

	// ==========================================================
	// Checks
	property p_add_hold;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		trim_evt && trim_ff.add_cycles |=> hold_ff == $past(trim_cycles);
	endproperty
	a_add_hold: assert property (p_add_hold) else $error("add trim not loaded");

	property p_sub_jump;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		trim_evt && !trim_ff.add_cycles
			|=> pre_ff == $past(pre_ff) + `RTDT_PRE_ONE + {7'h00, $past(trim_cycles)};
	endproperty
	a_sub_jump: assert property (p_sub_jump) else $error("subtract jump wrong");

	property p_hold_freeze;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		holding && osc_tick |=> $stable(pre_ff) && hold_ff == $past(hold_ff) - `RTDT_HOLD_ONE;
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("prescaler moved in hold");

	property p_zero_off;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		!trim_on && !holding && osc_tick |=> !holding && pre_ff == $past(pre_inc);
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("trim with zero magnitude");

	property p_coarse_rate;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		ctrl.coarse_trim_enable && trim_on && osc_tick && !holding
			&& pre_ff[`RTDT_SLOT_MSB:0] == `RTDT_SLOT_LAST |-> trim_evt;
	endproperty
	a_coarse_rate: assert property (p_coarse_rate) else $error("coarse slot missed");

	property p_fine_minute;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		trim_evt && !ctrl.coarse_trim_enable
			|-> sec_ff == `RTDT_SEC_LAST && pre_ff == `RTDT_PRE_LAST;
	endproperty
	a_fine_minute: assert property (p_fine_minute) else $error("fine trim off minute");

	property p_sqw_off;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		!ctrl.square_wave_enable ##1 !ctrl.square_wave_enable |-> !multi_function_output_pin;
	endproperty
	a_sqw_off: assert property (p_sqw_off) else $error("pin driven while disabled");

	property p_coarse_64;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		ctrl.square_wave_enable && ctrl.coarse_trim_enable
			|=> multi_function_output_pin == $past(pre_ff[`RTDT_TAP_64HZ]);
	endproperty
	a_coarse_64: assert property (p_coarse_64) else $error("64 Hz output wrong");

	property p_second_tick;
		@(posedge sys_clk) disable iff (!rst_sync_ff)
		second_tick |-> $past(sec_wrap) && $past(osc_tick) && !$past(holding)
			&& pre_ff == ($past(trim_evt && !trim_ff.add_cycles) ? $past(pre_jump) : '0);
	endproperty
	a_second_tick: assert property (p_second_tick) else $error("second tick misplaced");

endmodule : rtdt_trim

`default_nettype wire

//--- rtdt_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// 32.768 kHz source, scaled to 6 host clocks per cycle
module rtdt_osc_model (
	input wire logic run,
	output logic osc_out
);
	// Stopped crystal stands still low, no stray edges
	initial
	begin
		osc_out = 1'b0;
		forever
		begin
			#150;
			osc_out = run ? ~osc_out : 1'b0;
		end
	end
endmodule : rtdt_osc_model

`default_nettype wire

//--- rtc_digital_trim_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench
module rtc_digital_trim_tb_top;
	import rtdt_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc_run = 1'b0;
	wire logic osc_pin;
	rtdt_ctrl_t ctrl = '0;
	logic trim_wr = 1'b0;
	rtdt_trim_t trim_wdata = '0;
	rtdt_trim_t trim_rdata;
	rtdt_trim_t v;
	rtdt_trim_t prev;
	rtdt_trim_t cases[6] = '{8'h00, 8'h80, 8'h81, 8'h7F, 8'hFF, 8'h00};
	logic second_tick;
	logic [5:0] seconds_count;
	logic mfo;
	logic held;
	int miscompares = 0;
	int checked = 0;
	int osc_cnt = 0;
	int ticks = 0;
	int per;

	always #25 sys_clk = ~sys_clk;
	always @(posedge osc_pin) osc_cnt++;
	always @(posedge sys_clk) if (second_tick === 1'b1) ticks++;

	rtdt_osc_model osc (.run(osc_run), .osc_out(osc_pin));

	rtdt_trim uut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.osc_pin(osc_pin),
		.ctrl(ctrl),
		.trim_wr(trim_wr),
		.trim_wdata(trim_wdata),
		.trim_rdata(trim_rdata),
		.second_tick(second_tick),
		.seconds_count(seconds_count),
		.multi_function_output_pin(mfo)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic write_trim(input rtdt_trim_t t);
		trim_wr <= 1'b1;
		trim_wdata <= t;
		@(posedge sys_clk);
		trim_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : write_trim

	// Bounded wait for a rising edge on the output pin
	task automatic pin_rise;
		logic last;
		last = mfo;
		for (int n = 0; n < 20000; n++)
		begin
			@(posedge sys_clk);
			if (last === 1'b0 && mfo === 1'b1)
				return;
			last = mfo;
		end
		miscompares++;
		wrap_up();
	endtask : pin_rise

	// Output period counted in oscillator cycles
	task automatic period(output int p);
		int c0;
		pin_rise();
		c0 = osc_cnt;
		pin_rise();
		p = osc_cnt - c0;
	endtask : period

	// Coarse: two slots of 2*mag per 512-cycle period
	function automatic int exp_period(input rtdt_ctrl_t c, input rtdt_trim_t t);
		int step;
		step = 4 * int'(t.trim_magnitude);
		if (c.coarse_trim_enable)
			return t.add_cycles ? 512 + step : 512 - step;
		case (c.square_wave_rate_select)
			2'h0: return 32768;
			2'h3: return 1;
			2'h2: return 4;
			default: return 8;
		endcase
	endfunction : exp_period

	initial
	begin
		void'($urandom(32'h8A62));
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		prev = 8'h00;
		for (int i = 0; i < 6; i++)
		begin
			v = rtdt_trim_t'(8'($urandom));
			trim_wr <= 1'b1;
			trim_wdata <= v;
			@(posedge sys_clk);
			check("trim_rdata", trim_rdata, prev);
			prev = v;
		end
		trim_wr <= 1'b0;
		@(posedge sys_clk);
		check("trim_rdata", trim_rdata, prev);
		$display("test register done");
		// Trim cleared before the clock starts
		write_trim(8'h00);
		ctrl.osc_start <= 1'($urandom);
		ctrl.ext_clock_input_enable <= 1'b1;
		ctrl.square_wave_enable <= 1'b1;
		osc_run <= 1'b1;
		for (int r = 1; r < 4; r++)
		begin
			ctrl.square_wave_rate_select <= 2'(r);
			period(per);
			period(per);
			check("rate period", per, exp_period(ctrl, 8'h00));
		end
		// Both sources off: prescaler and pin must stand still
		ctrl.square_wave_rate_select <= 2'h2;
		ctrl.osc_start <= 1'b0;
		ctrl.ext_clock_input_enable <= 1'b0;
		repeat (4) @(posedge sys_clk);
		held = mfo;
		repeat (48)
		begin
			@(posedge sys_clk);
			check("stopped pin", mfo, held);
		end
		// Under half a second has run, so the 1 Hz level is still low
		ctrl.ext_clock_input_enable <= 1'b1;
		ctrl.square_wave_rate_select <= 2'h0;
		repeat (2) @(posedge sys_clk);
		repeat (48)
		begin
			@(posedge sys_clk);
			check("rate 1 Hz pin", mfo, 1'b0);
		end
		$display("test rates done");
		cases[5] = rtdt_trim_t'(8'($urandom) & 8'h9F);
		ctrl.coarse_trim_enable <= 1'b1;
		foreach (cases[i])
		begin
			write_trim(cases[i]);
			// First rise may close a slot run on the old trim
			pin_rise();
			pin_rise();
			repeat (2)
			begin
				per = osc_cnt;
				pin_rise();
				per = osc_cnt - per;
				check("coarse period", per, exp_period(ctrl, cases[i]));
			end
		end
		$display("test coarse done");
		check("seconds_count", seconds_count, 6'h00);
		check("second ticks", ticks, 0);
		$display("test time registers done");
		wrap_up();
	end
endmodule : rtc_digital_trim_tb_top

`default_nettype wire
